// file: verilog/pmc_pkg.sv
// Purpose: shared constants and types of the output macrocell array
// Assumes: eight macrocells with eight product terms each
// Notes:   register offsets are byte addresses on the plain register port
package pmc_pkg;
   // architecture modes, gray coded along reg -> cplx -> auto -> simp
   typedef enum logic [1:0] {
      PMC_MODE_REG  = 2'h0,
      PMC_MODE_CPLX = 2'h1,
      PMC_MODE_AUTO = 2'h3,
      PMC_MODE_SIMP = 2'h2
   } pmc_mode_e;

   // per-cell kinds
   localparam logic [1:0] KIND_IN   = 2'h0;
   localparam logic [1:0] KIND_COMB = 2'h1;
   localparam logic [1:0] KIND_REG  = 2'h2;

   // feedback selects
   localparam logic [1:0] FB_NONE = 2'h0;
   localparam logic [1:0] FB_PIN  = 2'h1;
   localparam logic [1:0] FB_REG  = 2'h2;
   localparam logic [1:0] FB_ALT  = 2'h3;

   // array geometry
   localparam int CELLS     = 8;
   localparam int PTS       = 8;
   localparam int OUTER_LO  = 0;
   localparam int OUTER_HI  = 7;
   localparam int CENTER_LO = 3;
   localparam int CENTER_HI = 4;

   // register map
   localparam int         AW          = 4;
   localparam logic [3:0] ADDR_MODE   = 4'h0;
   localparam logic [3:0] ADDR_KIND   = 4'h4;
   localparam logic [3:0] ADDR_OEUSE  = 4'h8;
   localparam logic [3:0] ADDR_STATUS = 4'hC;

   // field positions
   localparam int MODE_LSB     = 0;
   localparam int LOCK_BIT     = 4;
   localparam int ST_EFF_LSB   = 0;
   localparam int ST_REC_LSB   = 2;
   localparam int ST_MISS_BIT  = 4;
   localparam int ST_LOCK_BIT  = 5;
   localparam int ST_FB_LSB    = 8;
   localparam int ST_OE_LSB    = 16;

   // reset values
   localparam logic [1:0]  MODE_RST  = 2'h3;
   localparam logic [15:0] KIND_RST  = 16'h0000;
   localparam logic [7:0]  OEUSE_RST = 8'h00;
   localparam logic        Q_RST     = 1'b0;
   localparam logic        OUT_RST   = 1'b1;
endpackage

// file: verilog/pmc_sync.sv
// Purpose: two flip-flop synchroniser for pin levels
// Assumes: inputs are slow levels from pins
// Notes:   only the second stage leaves this module
`timescale 1ns/1ps
module pmc_sync #(
   parameter int W = 10
) (
   input  wire logic         clk,
   input  wire logic         rst_n,
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);
   logic [W-1:0] meta;   // first stage, read by q only

   // metastability filter
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         meta <= '0;
         q    <= '0;
      end
      else
      begin
         meta <= d;
         q    <= meta;
      end
   end
endmodule

// file: verilog/pmc_macrocell.sv
// Purpose: one output macrocell: sum, register, output enable, feedback
// Assumes: kind and selects come registered from the array top
// Notes:   all outputs are flip-flops, one cycle behind their causes
`timescale 1ns/1ps
module pmc_macrocell (
   input  wire logic       clk,
   input  wire logic       rst_n,
   input  wire logic [1:0] kind,
   input  wire logic       pt_oe_en,
   input  wire logic [1:0] fb_sel,
   input  wire logic       clk_edge,
   input  wire logic       oe_pin_n,
   input  wire logic [7:0] pt,
   input  wire logic       pin_s,
   input  wire logic       alt_s,
   output logic            pin_out,
   output logic            pin_oe,
   output logic            fb
);
   logic q;      // macrocell register
   logic sum8;   // all eight terms
   logic sum7;   // terms 7..1, term 0 kept for enable

   assign sum8 = |pt;
   assign sum7 = |pt[7:1];

   // register loads only on the common clock edge
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         q <= pmc_pkg::Q_RST;
      else if (kind == pmc_pkg::KIND_REG && clk_edge)
         q <= sum8;
   end

   // output data, inverted path so a cleared register drives high
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         pin_out <= pmc_pkg::OUT_RST;
      else if (kind == pmc_pkg::KIND_REG)
         pin_out <= ~q;
      else if (pt_oe_en)
         pin_out <= ~sum7;
      else
         pin_out <= ~sum8;
   end

   // output enable source per kind
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         pin_oe <= 1'b0;
      else
      begin
         case (kind)
            pmc_pkg::KIND_REG:  pin_oe <= ~oe_pin_n;
            pmc_pkg::KIND_COMB: pin_oe <= pt_oe_en ? pt[0] : 1'b1;
            default:            pin_oe <= 1'b0;
         endcase
      end
   end

   // feedback to the array; register path ignores the enable
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         fb <= 1'b0;
      else
      begin
         case (fb_sel)
            pmc_pkg::FB_REG: fb <= q;
            pmc_pkg::FB_PIN: fb <= pin_s;
            pmc_pkg::FB_ALT: fb <= alt_s;
            default:         fb <= 1'b0;
         endcase
      end
   end

   AST_REG_CAPTURE: assert property (@(posedge clk) disable iff (!rst_n)
      (kind == pmc_pkg::KIND_REG && clk_edge) |=> (q == $past(sum8)) ##1 (pin_out == !$past(sum8, 2)))
      else $error("register did not take the sum on the clock edge");
   AST_INPUT_OE_OFF: assert property (@(posedge clk) disable iff (!rst_n)
      (kind == pmc_pkg::KIND_IN) |=> !pin_oe)
      else $error("input cell drove its pin");
   AST_REG_OE_PIN: assert property (@(posedge clk) disable iff (!rst_n)
      (kind == pmc_pkg::KIND_REG) |=> (pin_oe == !$past(oe_pin_n)))
      else $error("registered enable not taken from the enable pin");
   AST_REG_FB: assert property (@(posedge clk) disable iff (!rst_n)
      (fb_sel == pmc_pkg::FB_REG && !clk_edge) |=> (fb == q))
      else $error("registered feedback differs from register");
   AST_COMB_SUM7: assert property (@(posedge clk) disable iff (!rst_n)
      (kind == pmc_pkg::KIND_COMB && pt_oe_en) |=> (pin_out == !$past(sum7) && pin_oe == $past(pt[0])))
      else $error("combinatorial cell used the wrong terms");
   AST_SIMPLE_OE_ON: assert property (@(posedge clk) disable iff (!rst_n)
      (kind == pmc_pkg::KIND_COMB && !pt_oe_en) |=> (pin_oe && pin_out == !$past(sum8)))
      else $error("simple cell not permanently enabled");
endmodule

// file: verilog/pmc_array.sv
// Contract
// - any register used forces registered mode
// - combinatorial with term enables selects complex mode
// - simple only for plain dedicated outputs
// - registered mode: control pins are clock, enable
// - complex: control pins enter via outer feedback
// - simple: feedback via neighbour, centre cells none; outer cells 0 and 7 feed back the control pins instead
// - registered mode: each cell reg, comb or input
// - register takes eight terms, enable from pin
// - registered-mode comb: term enable, seven terms
// - input cell never drives its pin
// - complex: six inner I/O, outer output-only
// - complex: seven terms plus enable term
// - simple: eight terms, centre always enabled
// - simple non-centre: input or fed-back output
// - exactly eight configurable macrocells
// - registers reset low, outputs start high
//
// Purpose: eight-cell output macrocell array with mode control
// Assumes: product terms come from an outside and-array on clk;
//          pins and both control pins are asynchronous levels
// Notes:   configuration is loaded over the register port and then locked
//
// Chosen here: the address-and-strobe port and the register addresses.
`timescale 1ns/1ps
module pmc_array #(
   parameter int NCELL = 8
) (
   input  wire logic              clk,
   input  wire logic              resetn,
   input  wire logic [3:0]        addr,
   input  wire logic [31:0]       wdata,
   input  wire logic              wr,
   input  wire logic              rd,
   output logic      [31:0]       rdata,
   input  wire logic [NCELL*8-1:0] pt,
   input  wire logic              ctl_clk_pin,
   input  wire logic              ctl_oe_n_pin,
   input  wire logic [NCELL-1:0]  io_in,
   output logic      [NCELL-1:0]  io_out,
   output logic      [NCELL-1:0]  io_oe,
   output logic      [NCELL-1:0]  array_fb
);
   // the cell routing below is written for exactly eight cells
   generate
      if (NCELL != pmc_pkg::CELLS)
      begin : g_bad
         $error("pmc_array serves exactly eight macrocells");
      end
   endgenerate

   logic                   rst_meta;     // reset release stage 1
   logic                   rst_n;        // released reset for the design
   logic [1:0]             mode_reg;     // requested mode
   logic                   lock;         // configuration frozen
   logic [2*NCELL-1:0]     kind_reg;     // requested kind per cell
   logic [NCELL-1:0]       oeuse_reg;    // cell wants a term enable
   logic [1:0]             eff_mode;     // mode in force
   logic [1:0]             rec_mode;     // mode the usage calls for
   logic                   mismatch;     // forced mode cannot serve usage
   logic [NCELL+1:0]       sync_q;       // synchronised pins
   logic [NCELL-1:0]       pin_s;        // synchronised io pins
   logic                   clk_s;        // synchronised common clock pin
   logic                   oe_n_s;       // synchronised common enable pin
   logic                   clk_d;        // previous clock pin level
   logic                   clk_edge;     // rising edge of common clock
   logic [NCELL-1:0]       alt;          // alternate feedback sources
   logic [1:0]             cell_kind [NCELL];
   logic [1:0]             cell_fb   [NCELL];
   logic                   pt_oe_en;     // term 0 is an enable
   logic                   any_reg;
   logic                   any_oe;
   logic [1:0]             next_rec;
   logic [1:0]             next_eff;

   // effective kind of cell idx under mode m for request k
   function automatic logic [1:0] kind_of(input logic [1:0] m, input logic [1:0] k, input int idx);
      logic [1:0] r;
      r = pmc_pkg::KIND_COMB;
      case (m)
         pmc_pkg::PMC_MODE_REG:
            r = (k == pmc_pkg::KIND_REG || k == pmc_pkg::KIND_COMB) ? k : pmc_pkg::KIND_IN;
         pmc_pkg::PMC_MODE_CPLX:
            if (idx == pmc_pkg::OUTER_LO || idx == pmc_pkg::OUTER_HI)
               r = pmc_pkg::KIND_COMB;
            else
               r = (k == pmc_pkg::KIND_IN) ? pmc_pkg::KIND_IN : pmc_pkg::KIND_COMB;
         default:
            if (idx == pmc_pkg::CENTER_LO || idx == pmc_pkg::CENTER_HI)
               r = pmc_pkg::KIND_COMB;
            else
               r = (k == pmc_pkg::KIND_IN) ? pmc_pkg::KIND_IN : pmc_pkg::KIND_COMB;
      endcase
      return r;
   endfunction

   // feedback path of cell idx under mode m with kind k
   function automatic logic [1:0] fb_of(input logic [1:0] m, input logic [1:0] k, input int idx);
      logic [1:0] r;
      r = pmc_pkg::FB_PIN;
      case (m)
         pmc_pkg::PMC_MODE_REG:
            r = (k == pmc_pkg::KIND_REG) ? pmc_pkg::FB_REG : pmc_pkg::FB_PIN;
         pmc_pkg::PMC_MODE_CPLX:
            if (idx == pmc_pkg::OUTER_LO || idx == pmc_pkg::OUTER_HI)
               r = pmc_pkg::FB_ALT;
            else
               r = pmc_pkg::FB_PIN;
         default:
            if (idx == pmc_pkg::CENTER_LO || idx == pmc_pkg::CENTER_HI)
               r = pmc_pkg::FB_NONE;
            else
               r = pmc_pkg::FB_ALT;
      endcase
      return r;
   endfunction

   // reset asserts at once, releases after two edges
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         rst_meta <= 1'b0;
         rst_n    <= 1'b0;
      end
      else
      begin
         rst_meta <= 1'b1;
         rst_n    <= rst_meta;
      end
   end

   // all pins cross into clk through two flops
   pmc_sync #(
      .W (NCELL + 2)
   ) u_sync (
      .clk   (clk),
      .rst_n (rst_n),
      .d     ({ctl_oe_n_pin, ctl_clk_pin, io_in}),
      .q     (sync_q)
   );
   assign pin_s  = sync_q[NCELL-1:0];
   assign clk_s  = sync_q[NCELL];
   assign oe_n_s = sync_q[NCELL+1];

   // edge detect on the clean copy of the clock pin
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         clk_d <= 1'b0;
      else
         clk_d <= clk_s;
   end
   assign clk_edge = clk_s & ~clk_d;

   // alternate feedback wiring: outer paths carry control pins,
   // inner paths carry the pin one step further out
   always_comb
   begin
      alt = '0;
      alt[pmc_pkg::OUTER_LO] = oe_n_s;
      alt[pmc_pkg::OUTER_HI] = clk_s;
      for (int i = 1; i <= pmc_pkg::CENTER_LO; i++)
         alt[i] = pin_s[i-1];
      for (int i = pmc_pkg::CENTER_HI; i < pmc_pkg::OUTER_HI; i++)
         alt[i] = pin_s[i+1];
   end

   // config writes; ignored once locked so nothing changes in use
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         mode_reg  <= pmc_pkg::MODE_RST;
         lock      <= 1'b0;
         kind_reg  <= pmc_pkg::KIND_RST;
         oeuse_reg <= pmc_pkg::OEUSE_RST;
      end
      else if (wr && !lock)
      begin
         case (addr)
            pmc_pkg::ADDR_MODE:
            begin
               mode_reg <= wdata[pmc_pkg::MODE_LSB +: 2];
               lock     <= wdata[pmc_pkg::LOCK_BIT];
            end
            pmc_pkg::ADDR_KIND:  kind_reg  <= wdata[2*NCELL-1:0];
            pmc_pkg::ADDR_OEUSE: oeuse_reg <= wdata[NCELL-1:0];
            default:             ;
         endcase
      end
   end

   // usage summary for mode choice
   always_comb
   begin
      any_reg = 1'b0;
      any_oe  = 1'b0;
      for (int i = 0; i < NCELL; i++)
      begin
         if (kind_reg[2*i +: 2] == pmc_pkg::KIND_REG)
            any_reg = 1'b1;
         if (kind_reg[2*i +: 2] == pmc_pkg::KIND_COMB && oeuse_reg[i])
            any_oe = 1'b1;
      end
      if (any_reg)
         next_rec = pmc_pkg::PMC_MODE_REG;
      else if (any_oe)
         next_rec = pmc_pkg::PMC_MODE_CPLX;
      else
         next_rec = pmc_pkg::PMC_MODE_SIMP;
      next_eff = (mode_reg == pmc_pkg::PMC_MODE_AUTO) ? next_rec : mode_reg;
   end

   // mode in force and its mismatch flag
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         rec_mode <= pmc_pkg::PMC_MODE_SIMP;
         eff_mode <= pmc_pkg::PMC_MODE_SIMP;
         mismatch <= 1'b0;
      end
      else
      begin
         rec_mode <= next_rec;
         eff_mode <= next_eff;
         // a forced simple mode cannot serve enables, only reg serves registers
         mismatch <= (any_reg && next_eff != pmc_pkg::PMC_MODE_REG) ||
                     (any_oe && next_eff == pmc_pkg::PMC_MODE_SIMP);
      end
   end

   assign pt_oe_en = (eff_mode != pmc_pkg::PMC_MODE_SIMP);

   // per-cell routing, registered so the cells see clean selects
   generate
      for (genvar g = 0; g < NCELL; g++)
      begin : g_cell
         always_ff @(posedge clk or negedge rst_n)
         begin
            if (!rst_n)
            begin
               cell_kind[g] <= pmc_pkg::KIND_IN;
               cell_fb[g]   <= pmc_pkg::FB_NONE;
            end
            else
            begin
               cell_kind[g] <= kind_of(eff_mode, kind_reg[2*g +: 2], g);
               cell_fb[g]   <= fb_of(eff_mode, kind_of(eff_mode, kind_reg[2*g +: 2], g), g);
            end
         end

         pmc_macrocell u_cell (
            .clk      (clk),
            .rst_n    (rst_n),
            .kind     (cell_kind[g]),
            .pt_oe_en (pt_oe_en),
            .fb_sel   (cell_fb[g]),
            .clk_edge (clk_edge),
            .oe_pin_n (oe_n_s),
            .pt       (pt[8*g +: 8]),
            .pin_s    (pin_s[g]),
            .alt_s    (alt[g]),
            .pin_out  (io_out[g]),
            .pin_oe   (io_oe[g]),
            .fb       (array_fb[g])
         );
      end
   endgenerate

   // read port, data one cycle after the strobe, unmapped reads zero
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         rdata <= 32'h0000_0000;
      else if (rd)
      begin
         rdata <= 32'h0000_0000;
         case (addr)
            pmc_pkg::ADDR_MODE:
            begin
               rdata[pmc_pkg::MODE_LSB +: 2] <= mode_reg;
               rdata[pmc_pkg::LOCK_BIT]      <= lock;
            end
            pmc_pkg::ADDR_KIND:  rdata[2*NCELL-1:0] <= kind_reg;
            pmc_pkg::ADDR_OEUSE: rdata[NCELL-1:0]   <= oeuse_reg;
            pmc_pkg::ADDR_STATUS:
            begin
               rdata[pmc_pkg::ST_EFF_LSB +: 2]    <= eff_mode;
               rdata[pmc_pkg::ST_REC_LSB +: 2]    <= rec_mode;
               rdata[pmc_pkg::ST_MISS_BIT]        <= mismatch;
               rdata[pmc_pkg::ST_LOCK_BIT]        <= lock;
               rdata[pmc_pkg::ST_FB_LSB +: NCELL] <= array_fb;
               rdata[pmc_pkg::ST_OE_LSB +: NCELL] <= io_oe;
            end
            default: ;
         endcase
      end
      else
         rdata <= 32'h0000_0000;
   end

   AST_AUTO_REG: assert property (@(posedge clk) disable iff (!rst_n)
      (mode_reg == pmc_pkg::PMC_MODE_AUTO && any_reg) |=> (eff_mode == pmc_pkg::PMC_MODE_REG))
      else $error("register usage did not select registered mode");
   AST_AUTO_SIMPLE: assert property (@(posedge clk) disable iff (!rst_n)
      (mode_reg == pmc_pkg::PMC_MODE_AUTO && !any_reg && !any_oe) |=> (eff_mode == pmc_pkg::PMC_MODE_SIMP))
      else $error("plain outputs did not select simple mode");
   AST_CENTER: assert property (@(posedge clk) disable iff (!rst_n)
      (eff_mode == pmc_pkg::PMC_MODE_SIMP && $stable(eff_mode)) |=>
      (cell_kind[3] == pmc_pkg::KIND_COMB && cell_fb[4] == pmc_pkg::FB_NONE))
      else $error("centre cell not a fixed output without feedback");
   AST_OUTER: assert property (@(posedge clk) disable iff (!rst_n)
      (eff_mode == pmc_pkg::PMC_MODE_CPLX && $stable(eff_mode)) |=>
      (cell_kind[0] != pmc_pkg::KIND_IN && cell_fb[7] == pmc_pkg::FB_ALT))
      else $error("outer cell misrouted in complex mode");
   AST_LOCK: assert property (@(posedge clk) disable iff (!rst_n)
      (lock && wr) |=> ($stable(kind_reg) && $stable(mode_reg) && $stable(oeuse_reg)))
      else $error("locked configuration changed");

   // term enables without registers pick complex mode
   AST_AUTO_CPLX: assert property (@(posedge clk) disable iff (!rst_n)
      (mode_reg == pmc_pkg::PMC_MODE_AUTO && !any_reg && any_oe) |=> (eff_mode == pmc_pkg::PMC_MODE_CPLX))
      else $error("term enables did not select complex mode");
   // registered mode keeps both control pins away from the array
   AST_REG_CTL: assert property (@(posedge clk) disable iff (!rst_n)
      (eff_mode == pmc_pkg::PMC_MODE_REG) |=>
      (cell_fb[0] != pmc_pkg::FB_ALT && cell_fb[7] != pmc_pkg::FB_ALT))
      else $error("control pin routed to the array in registered mode");
   // inner cells keep their own pin feedback in complex mode
   AST_INNER_IO: assert property (@(posedge clk) disable iff (!rst_n)
      (eff_mode == pmc_pkg::PMC_MODE_CPLX) |=>
      (cell_fb[1] == pmc_pkg::FB_PIN && cell_fb[6] == pmc_pkg::FB_PIN))
      else $error("inner cell lost pin feedback in complex mode");
   // a requested register is honoured in registered mode
   AST_REG_KIND: assert property (@(posedge clk) disable iff (!rst_n)
      (eff_mode == pmc_pkg::PMC_MODE_REG && kind_reg[1:0] == pmc_pkg::KIND_REG) |=>
      (cell_kind[0] == pmc_pkg::KIND_REG))
      else $error("registered request not honoured");
   // a forced simple mode cannot serve term enables, so it is flagged
   AST_SIMPLE_MISS: assert property (@(posedge clk) disable iff (!rst_n)
      (mode_reg == pmc_pkg::PMC_MODE_SIMP && any_oe) |=> mismatch)
      else $error("term enables in simple mode not flagged");
endmodule

// file: test/pmc_array_test.sv
// Purpose: self-checking bench of the eight-cell macrocell array
// Assumes: outputs settle within eight clocks of any input or config change
// Notes:   drivers note expected value and mask; a watcher compares in order
`timescale 1ns/1ps
module pmc_array_test;
   typedef struct {logic [31:0] v; logic [31:0] m;} pmc_note_s;

   logic        clk          = 1'b0;  // 10 MHz system clock
   logic        resetn       = 1'b0;  // held low for 16 clocks
   logic [3:0]  addr         = 4'h0;  // register address
   logic [31:0] wdata        = 32'h0;  // register write data
   logic        wr           = 1'b0;  // write strobe
   logic        rd           = 1'b0;  // read strobe
   logic [31:0] rdata;                // read data, cycle after rd
   logic [63:0] pt           = 64'h0;  // product terms into the cells
   logic        ctl_clk_pin  = 1'b0;  // common clock pin
   logic        ctl_oe_n_pin = 1'b1;  // common enable pin, active low
   logic [7:0]  ext          = 8'h00;  // far-side drive of each pin
   wire  [7:0]  io_in;                // resolved pin levels
   logic [7:0]  io_out;               // cell drive values
   logic [7:0]  io_oe;                // cell drive enables
   logic [7:0]  array_fb;             // feedback into the and-array
   logic        peek         = 1'b0;  // pin sample request
   logic        rd_d         = 1'b0;  // read answer due
   logic        peek_d       = 1'b0;  // pin sample due
   logic [15:0] kd;                   // kind pattern in use
   logic [31:0] e;                    // expected pin vector
   logic [31:0] m;                    // mask of defined bits
   pmc_note_s   notes[$];             // expected results, oldest first
   int          errors       = 0;     // mismatches
   int          checks       = 0;     // comparisons made
   int          cycles       = 0;     // timeout counter

   // a pin shows the cell's value while driven, the far side otherwise
   assign io_in = (io_oe & io_out) | (~io_oe & ext);

   pmc_array u_pmc_array (
      .clk          (clk),
      .resetn       (resetn),
      .addr         (addr),
      .wdata        (wdata),
      .wr           (wr),
      .rd           (rd),
      .rdata        (rdata),
      .pt           (pt),
      .ctl_clk_pin  (ctl_clk_pin),
      .ctl_oe_n_pin (ctl_oe_n_pin),
      .io_in        (io_in),
      .io_out       (io_out),
      .io_oe        (io_oe),
      .array_fb     (array_fb)
   );

   // clock generator
   always #50 clk = ~clk;

   task automatic test_done;
      errors += notes.size();   // notes never answered count as misses
      $display("checks %0d errors %0d", checks, errors);
      if (errors == 0 && checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp)
      begin
         errors++;
         $display("Error %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic idle(input int n);
      repeat (n) @(posedge clk);
   endtask

   task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask

   task automatic rd_reg(input logic [3:0] a, input logic [31:0] ev, input logic [31:0] em);
      notes.push_back('{ev, em});
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
   endtask

   // samples {feedback, enables, drive values} two edges after the request
   task automatic pins(input logic [31:0] ev, input logic [31:0] em);
      notes.push_back('{ev, em});
      @(posedge clk);
      peek <= 1'b1;
      @(posedge clk);
      peek <= 1'b0;
   endtask

   // expected pins in complex (smp=0) or simple (smp=1) mode
   function automatic void model(input logic smp, input logic [15:0] k, output logic [31:0] ev,
                                 output logic [31:0] em);
      logic [7:0] oe, out, lv, fb;
      for (int g = 0; g < 8; g++)
      begin
         oe[g] = smp ? (k[2*g] | (g == 3) | (g == 4)) : pt[8*g];
         out[g] = smp ? ~|pt[8*g+:8] : ~|pt[8*g+1+:7];
         lv[g] = oe[g] ? out[g] : ext[g];
      end
      // outer feedback carries the control pins; simple mode uses neighbours
      // centre cells 3 and 4 have no feedback path in simple mode
      fb = smp ? {ctl_clk_pin, lv[7:6], 2'b00, lv[1:0], ctl_oe_n_pin} : {ctl_clk_pin, lv[6:1], ctl_oe_n_pin};
      ev = {8'h00, fb, oe, out};
      em = {8'h00, 8'hFF, 8'hFF, smp ? oe : 8'hFF};
   endfunction

   // one rise and fall of the common clock pin
   task automatic tick;
      ctl_clk_pin <= 1'b1;
      idle(8);
      ctl_clk_pin <= 1'b0;
      idle(8);
   endtask

   // result watcher: takes the oldest note whenever a result appears
   always @(posedge clk)
   begin
      pmc_note_s n;
      if (rd_d || peek_d)
      begin
         n = notes.pop_front();
         if (rd_d)
            check("rdata", rdata & n.m, n.v & n.m);
         else
            check("pins", {8'h00, array_fb, io_oe, io_out} & n.m, n.v & n.m);
      end
      rd_d <= rd;
      peek_d <= peek;
   end

   // hang guard, far above the few hundred cycles needed
   always @(posedge clk)
   begin
      cycles++;
      if (cycles == 5000)
      begin
         errors++;
         test_done();
      end
   end

   initial
   begin
      void'($urandom(64408));
      idle(8);
      pins(32'h000000FF, 32'h00FFFFFF);
      idle(6);
      resetn <= 1'b1;
      idle(4);
      rd_reg(pmc_pkg::ADDR_MODE, 32'h3, 32'hFFFFFFFF);
      rd_reg(pmc_pkg::ADDR_KIND, 32'h0, 32'hFFFFFFFF);
      rd_reg(pmc_pkg::ADDR_OEUSE, 32'h0, 32'hFFFFFFFF);
      rd_reg(4'h2, 32'h0, 32'hFFFFFFFF);
      // automatic choice: register use, term enables, plain outputs; then a register under forced simple
      wr_reg(pmc_pkg::ADDR_KIND, 32'h2);
      idle(6);
      rd_reg(pmc_pkg::ADDR_STATUS, 32'h0, 32'h0C);
      wr_reg(pmc_pkg::ADDR_KIND, 32'h5555);
      wr_reg(pmc_pkg::ADDR_OEUSE, 32'h1);
      idle(6);
      rd_reg(pmc_pkg::ADDR_STATUS, 32'h4, 32'h0C);
      wr_reg(pmc_pkg::ADDR_OEUSE, 32'h0);
      idle(6);
      rd_reg(pmc_pkg::ADDR_STATUS, 32'h8, 32'h0C);
      wr_reg(pmc_pkg::ADDR_MODE, 32'h2);
      wr_reg(pmc_pkg::ADDR_KIND, 32'h2);
      idle(6);
      rd_reg(pmc_pkg::ADDR_STATUS, 32'h12, 32'h13);
      // registered mode: cell 0 register, cell 1 comb, rest inputs
      ext <= 8'hA4;
      pt <= 64'h0101;
      ctl_oe_n_pin <= 1'b0;
      wr_reg(pmc_pkg::ADDR_KIND, 32'h6);
      wr_reg(pmc_pkg::ADDR_MODE, 32'h0);
      idle(8);
      rd_reg(pmc_pkg::ADDR_STATUS, 32'h0, 32'h13);
      pins(32'h00A60303, 32'h00FFFF03);
      tick();
      pins(32'h00A70302, 32'h00FFFF03);
      ctl_oe_n_pin <= 1'b1;
      pt <= 64'h8000;
      idle(8);
      pins(32'h00A50000, 32'h00FFFF03);
      tick();
      pins(32'h00A40001, 32'h00FFFF03);
      // complex mode, outer cell 0 left as input must still drive
      wr_reg(pmc_pkg::ADDR_KIND, 32'h5554);
      wr_reg(pmc_pkg::ADDR_MODE, 32'h1);
      repeat (6)
      begin
         pt <= {$urandom, $urandom};
         ext <= 8'($urandom);
         {ctl_clk_pin, ctl_oe_n_pin} <= 2'($urandom);
         idle(8);
         model(1'b0, 16'h5554, e, m);
         pins(e, m);
      end
      // simple mode with random input or output cells
      wr_reg(pmc_pkg::ADDR_MODE, 32'h2);
      repeat (6)
      begin
         kd = 16'($urandom) & 16'h5555;
         wr_reg(pmc_pkg::ADDR_KIND, {16'h0, kd});
         pt <= {$urandom, $urandom};
         ext <= 8'($urandom);
         {ctl_clk_pin, ctl_oe_n_pin} <= 2'($urandom);
         idle(8);
         model(1'b1, kd, e, m);
         pins(e, m);
      end
      // term enables under forced simple mode: complex advised, flagged
      kd = 16'h5555;
      wr_reg(pmc_pkg::ADDR_KIND, {16'h0, kd});
      wr_reg(pmc_pkg::ADDR_OEUSE, 32'hFF);
      idle(4);
      rd_reg(pmc_pkg::ADDR_STATUS, 32'h16, 32'h1F);
      // locked configuration ignores later writes
      wr_reg(pmc_pkg::ADDR_MODE, 32'h12);
      wr_reg(pmc_pkg::ADDR_KIND, 32'hFFFF);
      rd_reg(pmc_pkg::ADDR_KIND, {16'h0, kd}, 32'hFFFFFFFF);
      rd_reg(pmc_pkg::ADDR_STATUS, 32'h20, 32'h20);
      // second reset in mid-run, only after the pending read is checked
      idle(2);
      resetn <= 1'b0;
      pins(32'h000000FF, 32'h00FFFFFF);
      resetn <= 1'b1;
      idle(4);
      rd_reg(pmc_pkg::ADDR_MODE, 32'h3, 32'hFFFFFFFF);
      idle(4);
      test_done();
   end
endmodule
